/* design/rir_core.sv */
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
module rir_core (
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// Register port
	input wire logic [3:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// Pins
	input wire logic [7:1] irq_n_i,
	input wire logic ext_reset_i,
	output logic ext_reset_o,
	output logic ext_reset_oe_o,
	input wire logic pll_lock_i,
	input wire logic breakpoint_input_n_i,
	input wire logic boot_ram_i,
	output logic boot_cs_n_o,
	// Core side
	input wire logic int_rst_req_i,
	input wire logic bus_cycle_end_i,
	input wire logic insn_boundary_i,
	input wire logic exc_done_i,
	input wire logic fetch_ack_i,
	input wire logic [31:0] fetch_data_i,
	output logic fetch_req_o,
	output logic [31:0] fetch_addr_o,
	output logic master_reset_o,
	output logic module_reset_o,
	output logic abort_o,
	output logic cpu_run_o,
	output logic int_pend_o,
	output logic [2:0] int_level_o,
	output logic iack_o,
	output logic [2:0] iack_level_o
);

	// Whole state of the block
	typedef struct packed {
		rir_pkg::rir_rs_t rs;
		logic [9:0] cnt;
		logic [2:0] mrcnt;
		logic mrst;
		logic modrst;
		logic ext_drv;
		logic pin_lvl;
		logic abort;
		logic rst_pend;
		logic [3:0] cause_acc;
		logic [3:0] cause;
		logic [2:0] mask;
		logic sup;
		logic tr_lo;
		logic tr_hi;
		logic [31:0] vector_table_base;
		logic [31:0] isp;
		logic [31:0] pc;
		logic breakpoint_input;
		logic boot_ram;
		logic fetch_req;
		logic [31:0] fetch_addr;
		logic boot_cs_n;
		logic run;
		logic nmi_pend;
		logic nonmaskable_request_line_prev;
		logic [2:0] mask_prev;
		logic [2:0] pend_lvl;
		logic int_pend;
		logic iack;
		logic [2:0] iack_lvl;
		logic [7:0] vecnum;
		logic [31:0] rdata;
	} rir_st_t;

	rir_st_t st; // Registered state
	rir_st_t next_st; // Next state

	logic [10:0] sync_q; // Synchronised pins
	logic [7:1] irq_s; // Request lines, active low
	logic ext_pin_s; // Reset pin level
	logic breakpoint_input_n_s; // Breakpoint input level
	logic lock_s; // PLL lock
	logic boot_s; // Boot from internal RAM strap

	// Translate a vector number into its table address
	function automatic logic [31:0] vec_addr(input logic [31:0] base,
		input logic [7:0] num);
		return base + {22'h00_0000, num, 2'h0};
	endfunction : vec_addr

	// Highest request level above the mask; level 7 only by its edge or a mask drop from 7
	function automatic logic [2:0] pick_level(input logic [6:1] act,
		input logic [2:0] m, input logic nmi);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 1; i < 7; i++)
		begin
			// Later loop passes are higher levels and overwrite
			if (act[i] && (3'(i) > m))
			begin
				r = 3'(i);
			end
		end
		if (nmi)
		begin
			r = rir_pkg::LVL_NMI;
		end
		return r;
	endfunction : pick_level

	// Pin synchroniser, idle levels at reset
	rir_sync #(
		.W(11),
		.RST_VAL(11'h5FF)
	) u_sync (
		.sys_clk_i(sys_clk_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.d_i({boot_ram_i, pll_lock_i, breakpoint_input_n_i, ext_reset_i, irq_n_i}),
		.q_o(sync_q)
	);

	assign irq_s = sync_q[6:0];
	assign ext_pin_s = sync_q[7];
	assign breakpoint_input_n_s = sync_q[8];
	assign lock_s = sync_q[9];
	assign boot_s = sync_q[10];

	// Sequencing, registers and interrupt recognition
	always_comb
	begin
		logic sw_rst;
		logic [3:0] reqs;
		logic [2:0] lvl;
		logic nmi_set;
		logic nmi_clr;
		next_st = st;
		sw_rst = wr_i && (addr_i == rir_pkg::REG_CTRL)
			&& wdata_i[rir_pkg::CTRL_SWRST_BIT];
		reqs = '0;
		reqs[rir_pkg::CAUSE_EXT] = !ext_pin_s;
		reqs[rir_pkg::CAUSE_SW] = sw_rst;
		reqs[rir_pkg::CAUSE_INT] = int_rst_req_i;
		nmi_clr = 1'b0;
		nmi_set = 1'b0;
		lvl = 3'h0;
		next_st.abort = 1'b0;
		next_st.iack = 1'b0;
		next_st.pin_lvl = 1'b0;
		next_st.rdata = '0;
		next_st.nonmaskable_request_line_prev = irq_s[7];
		next_st.mask_prev = st.mask;

		// Reset sequencer
		case (st.rs)
			rir_pkg::RS_POR:
			begin
				// Pin held until the synthesizer locks
				if (lock_s)
				begin
					next_st.rs = rir_pkg::RS_DRIVE;
					next_st.cnt = '0;
				end
			end
			rir_pkg::RS_DRIVE:
			begin
				// Drive pin low for the full period
				if (st.cnt == rir_pkg::DRIVE_LAST)
				begin
					next_st.rs = rir_pkg::RS_FLOAT;
					next_st.cnt = '0;
					next_st.ext_drv = 1'b0;
				end
				else
				begin
					next_st.cnt = st.cnt + 10'h001;
				end
			end
			rir_pkg::RS_FLOAT:
			begin
				// Float pin, then test it
				if (st.cnt != rir_pkg::FLOAT_LAST)
				begin
					next_st.cnt = st.cnt + 10'h001;
				end
				else if (reqs == 4'h0)
				begin
					// Release: causes become visible now
					next_st.rs = rir_pkg::RS_BREAKPOINT_INPUT;
					next_st.mrst = 1'b0;
					next_st.cause = st.cause_acc;
					next_st.cause_acc = '0;
				end
				else
				begin
					// Still held: another drive period
					next_st.rs = rir_pkg::RS_DRIVE;
					next_st.cnt = '0;
					next_st.ext_drv = 1'b1;
					next_st.cause_acc = st.cause_acc | reqs;
				end
			end
			rir_pkg::RS_BREAKPOINT_INPUT:
			begin
				// Breakpoint sampled ahead of any vector fetch
				next_st.breakpoint_input = !breakpoint_input_n_s;
				next_st.boot_ram = boot_s;
				next_st.rs = rir_pkg::RS_FSP;
				next_st.fetch_req = 1'b1;
				next_st.fetch_addr = vec_addr(st.vector_table_base, rir_pkg::VEC_SP);
				next_st.boot_cs_n = boot_s;
			end
			rir_pkg::RS_FSP:
			begin
				// First long word: stack pointer
				if (fetch_ack_i)
				begin
					next_st.isp = fetch_data_i;
					next_st.rs = rir_pkg::RS_FPC;
					next_st.fetch_addr = vec_addr(st.vector_table_base, rir_pkg::VEC_PC);
				end
			end
			rir_pkg::RS_FPC:
			begin
				// Second long word: program counter, then run
				if (fetch_ack_i)
				begin
					next_st.pc = fetch_data_i;
					next_st.rs = rir_pkg::RS_RUN;
					next_st.fetch_req = 1'b0;
					next_st.boot_cs_n = 1'b1;
					next_st.run = 1'b1;
				end
			end
			rir_pkg::RS_RUN:
			begin
				// Normal operation
				next_st.run = 1'b1;
			end
			default:
			begin
				next_st.rs = rir_pkg::RS_POR;
			end
		endcase

		// Reset requests outside master reset wait for bus cycle end
		if (!st.mrst)
		begin
			if (reqs != 4'h0)
			begin
				next_st.rst_pend = 1'b1;
				next_st.cause_acc = st.cause_acc | reqs;
			end
			if ((st.rst_pend || (reqs != 4'h0)) && bus_cycle_end_i)
			begin
				next_st.rs = rir_pkg::RS_DRIVE;
				next_st.cnt = '0;
				next_st.mrst = 1'b1;
				next_st.ext_drv = 1'b1;
				next_st.abort = 1'b1;
				next_st.run = 1'b0;
				next_st.rst_pend = 1'b0;
				next_st.fetch_req = 1'b0;
				next_st.boot_cs_n = 1'b1;
			end
		end

		// Modules follow master reset after it has stood four cycles
		if (!st.mrst)
		begin
			next_st.modrst = 1'b0;
			next_st.mrcnt = '0;
		end
		else if (!st.modrst)
		begin
			if (st.mrcnt == rir_pkg::MRST_LAST)
			begin
				next_st.modrst = 1'b1;
			end
			else
			begin
				next_st.mrcnt = st.mrcnt + 3'h1;
			end
		end

		// Register writes
		if (wr_i)
		begin
			case (addr_i)
				rir_pkg::REG_SR:
				begin
					next_st.mask = wdata_i[rir_pkg::SR_MASK_LSB +: 3];
					next_st.sup = wdata_i[rir_pkg::SR_SUP_BIT];
					next_st.tr_lo = wdata_i[rir_pkg::SR_TLO_BIT];
					next_st.tr_hi = wdata_i[rir_pkg::SR_THI_BIT];
				end
				rir_pkg::REG_VTB:
				begin
					next_st.vector_table_base = wdata_i;
				end
				rir_pkg::REG_VECNUM:
				begin
					next_st.vecnum = wdata_i[7:0];
				end
				default:
				begin
					// Other offsets take no stored value
				end
			endcase
		end

		// Level-7 edge and mask-drop detection
		nmi_set = (st.nonmaskable_request_line_prev && !irq_s[7])
			|| ((st.mask_prev == rir_pkg::LVL_NMI)
			&& (st.mask != rir_pkg::LVL_NMI) && !irq_s[7]);

		// Live priority pick, recomputed every cycle
		lvl = pick_level(~irq_s[6:1], st.mask, st.nmi_pend);
		next_st.pend_lvl = lvl;
		next_st.int_pend = st.run && (lvl != 3'h0);

		// Service only at a boundary or after exception processing
		if (st.run && !st.rst_pend && (lvl != 3'h0)
			&& (insn_boundary_i || exc_done_i))
		begin
			next_st.iack = 1'b1;
			next_st.iack_lvl = lvl;
			next_st.mask = lvl;
			next_st.sup = 1'b1;
			next_st.tr_lo = 1'b0;
			next_st.tr_hi = 1'b0;
			nmi_clr = (lvl == rir_pkg::LVL_NMI);
		end

		// A new edge in the clearing cycle is kept
		next_st.nmi_pend = nmi_set || (st.nmi_pend && !nmi_clr);

		// Processor state forced while master reset stands
		if (next_st.mrst)
		begin
			next_st.mask = rir_pkg::MASK_RST;
			next_st.sup = 1'b1;
			next_st.tr_lo = 1'b0;
			next_st.tr_hi = 1'b0;
			next_st.vector_table_base = rir_pkg::VTB_RST;
		end

		// Read data for the following cycle only
		if (rd_i)
		begin
			case (addr_i)
				rir_pkg::REG_SR:
				begin
					next_st.rdata = {26'h000_0000, st.tr_hi, st.tr_lo, st.sup,
						st.mask};
				end
				rir_pkg::REG_VTB:
				begin
					next_st.rdata = st.vector_table_base;
				end
				rir_pkg::REG_CAUSE:
				begin
					next_st.rdata = {28'h000_0000, st.cause};
				end
				rir_pkg::REG_VECNUM:
				begin
					next_st.rdata = {24'h00_0000, st.vecnum};
				end
				rir_pkg::REG_VECADDR:
				begin
					next_st.rdata = vec_addr(st.vector_table_base, st.vecnum);
				end
				rir_pkg::REG_CTRL:
				begin
					next_st.rdata = {25'h000_0000, st.boot_ram, st.breakpoint_input,
						st.int_pend, st.pend_lvl, st.run};
				end
				rir_pkg::REG_ISP:
				begin
					next_st.rdata = st.isp;
				end
				rir_pkg::REG_PC:
				begin
					next_st.rdata = st.pc;
				end
				default:
				begin
					// Unmapped offsets read zero
					next_st.rdata = '0;
				end
			endcase
		end
	end

	// State register: synchronous reset starts power-on sequence
	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
		begin
			st <= '0;
			st.rs <= rir_pkg::RS_POR;
			st.mrst <= 1'b1;
			st.ext_drv <= 1'b1;
			st.mask <= rir_pkg::MASK_RST;
			st.mask_prev <= rir_pkg::MASK_RST;
			st.sup <= 1'b1;
			st.boot_cs_n <= 1'b1;
			st.nonmaskable_request_line_prev <= 1'b1;
			st.cause_acc <= 4'h1;
		end
		else if (ce_i)
		begin
			st <= next_st;
		end
	end

	// Outputs straight from state
	assign rdata_o = st.rdata;
	assign ext_reset_o = st.pin_lvl;
	assign ext_reset_oe_o = st.ext_drv;
	assign boot_cs_n_o = st.boot_cs_n;
	assign fetch_req_o = st.fetch_req;
	assign fetch_addr_o = st.fetch_addr;
	assign master_reset_o = st.mrst;
	assign module_reset_o = st.modrst;
	assign abort_o = st.abort;
	assign cpu_run_o = st.run;
	assign int_pend_o = st.int_pend;
	assign int_level_o = st.pend_lvl;
	assign iack_o = st.iack;
	assign iack_level_o = st.iack_lvl;

	// Checks
	AST_POR_LOCK: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(st.rs == rir_pkg::RS_DRIVE && $past(st.rs) == rir_pkg::RS_POR)
		|-> $past(lock_s) && ext_reset_oe_o)
		else $error("drive began without lock");
	AST_DRIVE_LEN: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(st.rs == rir_pkg::RS_FLOAT && $past(st.rs) == rir_pkg::RS_DRIVE)
		|-> $past(st.cnt) == rir_pkg::DRIVE_LAST)
		else $error("drive period wrong length");
	AST_MOD_AFTER4: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		$rose(module_reset_o) |-> $past(master_reset_o, 1)
		&& $past(master_reset_o, 4))
		else $error("modules reset too early");
	AST_FLOAT_FREE: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(st.rs == rir_pkg::RS_FLOAT) |-> !ext_reset_oe_o)
		else $error("pin driven while floating");
	AST_RST_STATE: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		master_reset_o |-> st.mask == 3'h7 && st.sup && !st.tr_lo
		&& !st.tr_hi && st.vector_table_base == 32'h0000_0000)
		else $error("core state not initialised");
	AST_BREAKPOINT_INPUT_FIRST: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		$rose(fetch_req_o) |-> $past(st.rs) == rir_pkg::RS_BREAKPOINT_INPUT)
		else $error("fetch before breakpoint sample");
	AST_CAUSE_REL: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		$changed(st.cause) |-> $past(st.rs) == rir_pkg::RS_FLOAT
		&& !master_reset_o)
		else $error("cause flags moved outside release");
	AST_MASK_GATE: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(ce_i && int_level_o != 3'h0 && int_level_o != 3'h7)
		|-> int_level_o > $past(st.mask))
		else $error("masked level reported");
	AST_IACK_MASK: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(iack_o && !master_reset_o) |-> st.mask == iack_level_o)
		else $error("mask not loaded on acknowledge");
	AST_ABORT_BUS: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		abort_o |-> $past(bus_cycle_end_i) && master_reset_o)
		else $error("reset taken mid bus cycle");

endmodule : rir_core

/* design/rir_pkg.sv */
// Shared constants for reset sequencing and interrupt recognition
package rir_pkg;

	// Register bus geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;

	// Register indices on the plain register port
	localparam logic [3:0] REG_SR = 4'h0;      // Status: mask, supervisor, trace
	localparam logic [3:0] REG_VTB = 4'h1;     // Vector table base
	localparam logic [3:0] REG_CAUSE = 4'h2;   // Reset cause flags
	localparam logic [3:0] REG_VECNUM = 4'h3;  // Vector number to translate
	localparam logic [3:0] REG_VECADDR = 4'h4; // Translated vector address
	localparam logic [3:0] REG_CTRL = 4'h5;    // Control and core state
	localparam logic [3:0] REG_ISP = 4'h6;     // Loaded interrupt stack pointer
	localparam logic [3:0] REG_PC = 4'h7;      // Loaded program counter

	// Status register fields
	localparam int SR_MASK_LSB = 0;
	localparam int SR_SUP_BIT = 3;
	localparam int SR_TLO_BIT = 4;
	localparam int SR_THI_BIT = 5;

	// Control register fields
	localparam int CTRL_SWRST_BIT = 0; // Write: software reset request
	localparam int CTRL_RUN_BIT = 0;   // Read: core running
	localparam int CTRL_LVL_LSB = 1;   // Read: pending level
	localparam int CTRL_PEND_BIT = 4;  // Read: interrupt pending
	localparam int CTRL_BREAKPOINT_INPUT_BIT = 5;  // Read: breakpoint seen at release
	localparam int CTRL_BOOT_BIT = 6;  // Read: vectors from internal RAM

	// Reset cause flag positions
	localparam int CAUSE_POR = 0;
	localparam int CAUSE_EXT = 1;
	localparam int CAUSE_SW = 2;
	localparam int CAUSE_INT = 3;
	localparam int CAUSE_W = 4;

	// Reset values and the non-maskable level
	localparam logic [2:0] MASK_RST = 3'h7;
	localparam logic [31:0] VTB_RST = 32'h0000_0000;
	localparam logic [2:0] LVL_NMI = 3'h7;

	// Reset vector numbers: stack pointer, then program counter
	localparam logic [7:0] VEC_SP = 8'h00;
	localparam logic [7:0] VEC_PC = 8'h01;

	// Timing counts in system clock cycles
	localparam int CNT_W = 10;
	localparam logic [9:0] DRIVE_LAST = 10'h1FF; // 512 cycles driven
	localparam logic [9:0] FLOAT_LAST = 10'h009; // 10 cycles floated
	localparam logic [2:0] MRST_LAST = 3'h3;     // 4 cycles before modules

	// Reset sequencer states, Gray coded along the path
	typedef enum logic [2:0] {
		RS_POR = 3'h0,
		RS_DRIVE = 3'h1,
		RS_FLOAT = 3'h3,
		RS_BREAKPOINT_INPUT = 3'h2,
		RS_FSP = 3'h6,
		RS_FPC = 3'h7,
		RS_RUN = 3'h5
	} rir_rs_t;

endpackage : rir_pkg

/* design/rir_sync.sv */
`timescale 1ns/10ps
// Three-stage pin synchroniser; output moves once stages two and three agree
module rir_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	// Whole state of the synchroniser
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} rir_sync_st_t;

	rir_sync_st_t st; // Registered state
	rir_sync_st_t next_st; // Next state

	// Shift chain and agreement filter
	always_comb
	begin
		next_st = st;
		next_st.s1 = d_i;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < W; i++)
		begin
			// Two agreeing samples make a valid level
			if (st.s2[i] == st.s3[i])
			begin
				next_st.q[i] = st.s3[i];
			end
		end
	end

	// State register
	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
		begin
			st <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
		end
		else if (ce_i)
		begin
			st <= next_st;
		end
	end

	assign q_o = st.q;

endmodule : rir_sync

/* sim/rir_far.sv */
`timescale 1ns/10ps
// Far side: request sources, reset pin pull-up, vector memory
module rir_far (
	input wire logic sys_clk_i,
	input wire logic [7:1] raise_i, // Pulse: start a request
	input wire logic [7:1] hold_i, // Keep line low past its ack
	input wire logic [7:1] drop_i, // Pulse: release line unacked
	input wire logic iack_i,
	input wire logic [2:0] iack_level_i,
	input wire logic ext_low_i, // Outside device pulls pin low
	input wire logic ext_oe_i,
	input wire logic ext_val_i,
	input wire logic slow_i, // Answer vector reads late
	input wire logic fetch_req_i,
	input wire logic [31:0] fetch_addr_i,
	output logic [7:1] irq_n_o,
	output logic ext_pin_o,
	output logic fetch_ack_o,
	output logic [31:0] fetch_data_o
);
	logic [7:1] req = '0; // Lines pulled low
	logic [1:0] dly = '0; // Slow answer counter
	initial fetch_ack_o = 1'b0;
	initial fetch_data_o = 32'h0000_0000;

	// Each source holds its line until its own level is acked
	always @(posedge sys_clk_i)
	begin
		for (int i = 1; i < 8; i++)
			if (drop_i[i])
				req[i] <= 1'b0;
			else if (raise_i[i])
				req[i] <= 1'b1;
			else if (iack_i && iack_level_i == 3'(i) && !hold_i[i])
				req[i] <= 1'b0;
	end
	assign irq_n_o = ~req;

	// Open-drain reset pin with pull-up
	assign ext_pin_o = !((ext_oe_i && !ext_val_i) || ext_low_i);

	// Vector memory; data toggle when not answering
	always @(posedge sys_clk_i)
	begin
		if (fetch_req_i && !fetch_ack_o && (!slow_i || dly == 2'h3))
		begin
			fetch_ack_o <= 1'b1;
			fetch_data_o <= fetch_addr_i ^ 32'hA5A5_0000;
			dly <= 2'h0;
		end
		else
		begin
			fetch_ack_o <= 1'b0;
			fetch_data_o <= ~fetch_data_o;
			dly <= fetch_req_i ? dly + 2'h1 : 2'h0;
		end
	end
endmodule : rir_far

/* sim/testbench.sv */
`timescale 1ns/10ps
// Bench for reset sequencing and interrupt recognition
module testbench;
	logic sys_clk_i, rstn_i, wr_i, rd_i, pll_lock_i, breakpoint_input_n_i, boot_ram_i;
	logic int_rst_req_i, bus_cycle_end_i, insn_boundary_i, exc_done_i;
	logic ext_low, slow;
	logic [3:0] addr_i;
	logic [31:0] wdata_i, d;
	logic [7:1] raise, hold, drop;
	wire logic [31:0] rdata_o, fetch_addr_o, fetch_data_i;
	wire logic [7:1] irq_n_i;
	wire logic [2:0] int_level_o, iack_level_o;
	wire logic ext_reset_i, ext_reset_o, ext_reset_oe_o, boot_cs_n_o;
	wire logic fetch_ack_i, fetch_req_o, master_reset_o, module_reset_o;
	wire logic abort_o, cpu_run_o, int_pend_o, iack_o;
	int bad_count = 0;
	int n_compared = 0;
	int t0;
	// Ordinary register cases
	typedef struct {logic [3:0] a; logic w; logic [31:0] d, e;} rir_row_t;
	rir_row_t rows [8] = '{
		'{rir_pkg::REG_VTB, 1'b1, 32'h0000_1000, 32'h0000_1000},
		'{rir_pkg::REG_VECNUM, 1'b1, 32'h0000_0005, 32'h0000_0005},
		'{rir_pkg::REG_VECADDR, 1'b0, 32'h0000_0000, 32'h0000_1014},
		'{rir_pkg::REG_VECNUM, 1'b1, 32'h0000_00FF, 32'h0000_00FF},
		'{rir_pkg::REG_VECADDR, 1'b0, 32'h0000_0000, 32'h0000_13FC},
		'{rir_pkg::REG_CAUSE, 1'b1, 32'hFFFF_FFFF, 32'h0000_0001},
		'{4'hF, 1'b1, 32'h0000_00FF, 32'h0000_0000},
		'{rir_pkg::REG_VTB, 1'b1, 32'h0000_0000, 32'h0000_0000}};

	rir_core DUT (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ce_i(1'b1),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .irq_n_i(irq_n_i), .ext_reset_i(ext_reset_i),
		.ext_reset_o(ext_reset_o), .ext_reset_oe_o(ext_reset_oe_o),
		.pll_lock_i(pll_lock_i), .breakpoint_input_n_i(breakpoint_input_n_i),
		.boot_ram_i(boot_ram_i), .boot_cs_n_o(boot_cs_n_o),
		.int_rst_req_i(int_rst_req_i), .bus_cycle_end_i(bus_cycle_end_i),
		.insn_boundary_i(insn_boundary_i), .exc_done_i(exc_done_i),
		.fetch_ack_i(fetch_ack_i), .fetch_data_i(fetch_data_i),
		.fetch_req_o(fetch_req_o), .fetch_addr_o(fetch_addr_o),
		.master_reset_o(master_reset_o), .module_reset_o(module_reset_o),
		.abort_o(abort_o), .cpu_run_o(cpu_run_o), .int_pend_o(int_pend_o),
		.int_level_o(int_level_o), .iack_o(iack_o),
		.iack_level_o(iack_level_o));

	rir_far far (.sys_clk_i(sys_clk_i), .raise_i(raise), .hold_i(hold),
		.drop_i(drop), .iack_i(iack_o), .iack_level_i(iack_level_o),
		.ext_low_i(ext_low), .ext_oe_i(ext_reset_oe_o),
		.ext_val_i(ext_reset_o), .slow_i(slow), .fetch_req_i(fetch_req_o),
		.fetch_addr_i(fetch_addr_o), .irq_n_o(irq_n_i),
		.ext_pin_o(ext_reset_i), .fetch_ack_o(fetch_ack_i),
		.fetch_data_o(fetch_data_i));

	// Clock
	initial
	begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	// Verdict and end of run
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			bad_count++;
		end
	endtask : chk

	// Register write, one strobe cycle
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
		@(negedge sys_clk_i);
	endtask : wr_reg

	// Register read; data stand the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		@(negedge sys_clk_i);
		d = rdata_o;
	endtask : rd_reg

	// Signal picker for bounded waits
	function automatic logic sel(input int s);
		case (s)
			0: return master_reset_o;
			1: return ext_reset_oe_o;
			2: return module_reset_o;
			3: return fetch_req_o;
			4: return cpu_run_o;
			5: return int_pend_o;
			default: return iack_o;
		endcase
	endfunction : sel

	// Bounded wait at falling edges
	task automatic wait_sig(input int s, input logic v);
		int n;
		n = 0;
		while (sel(s) !== v)
		begin
			@(negedge sys_clk_i);
			n++;
			if (n > 1200)
			begin
				bad_count++;
				summarize();
			end
		end
	endtask : wait_sig

	// Cycles since t0
	function automatic logic [31:0] gap();
		return 32'(($time - t0) / 10);
	endfunction : gap

	// Source pulses
	task automatic req(input logic [7:1] r, h, dr);
		@(posedge sys_clk_i);
		raise <= r;
		hold <= h;
		drop <= dr;
		@(posedge sys_clk_i);
		raise <= '0;
		drop <= '0;
		@(negedge sys_clk_i);
	endtask : req

	// Service point, then acknowledge check
	task automatic serve(input logic ex, input logic [2:0] lvl);
		@(posedge sys_clk_i);
		insn_boundary_i <= ~ex;
		exc_done_i <= ex;
		@(posedge sys_clk_i);
		insn_boundary_i <= 1'b0;
		exc_done_i <= 1'b0;
		@(negedge sys_clk_i);
		wait_sig(6, 1'b1);
		chk(32'(iack_level_o), 32'(lvl));
	endtask : serve

	// Main sequence
	initial
	begin
		{rstn_i, wr_i, rd_i, pll_lock_i, breakpoint_input_n_i, boot_ram_i} = '0;
		{int_rst_req_i, bus_cycle_end_i, insn_boundary_i, exc_done_i} = '0;
		{ext_low, slow, raise, hold, drop, addr_i, wdata_i} = '0;
		repeat (16) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		@(negedge sys_clk_i);
		chk(32'({master_reset_o, ext_reset_oe_o}), 32'h0000_0003);
		chk(32'(ext_reset_o), 32'h0000_0000);
		rd_reg(rir_pkg::REG_SR);
		chk(d, 32'h0000_000F);
		wr_reg(rir_pkg::REG_VTB, 32'h0000_1000);
		rd_reg(rir_pkg::REG_VTB);
		chk(d, 32'h0000_0000);
		repeat (40) @(negedge sys_clk_i);
		chk(32'(ext_reset_oe_o), 32'h0000_0001);
		@(posedge sys_clk_i);
		pll_lock_i <= 1'b1;
		t0 = $time;
		wait_sig(1, 1'b0);
		// Lock passes the synchroniser and the idle state before 512
		chk(gap(), 32'h0000_0205);
		t0 = $time;
		wait_sig(0, 1'b0);
		chk(gap(), 32'h0000_000A);
		t0 = $time;
		wait_sig(3, 1'b1);
		chk(gap(), 32'h0000_0001);
		chk(fetch_addr_o, 32'h0000_0000);
		chk(32'(boot_cs_n_o), 32'h0000_0000);
		wait_sig(4, 1'b1);
		rd_reg(rir_pkg::REG_ISP);
		chk(d, 32'hA5A5_0000);
		rd_reg(rir_pkg::REG_PC);
		chk(d, 32'hA5A5_0004);
		rd_reg(rir_pkg::REG_CTRL);
		chk(d, 32'h0000_0021);
		rd_reg(rir_pkg::REG_CAUSE);
		chk(d, 32'h0000_0001);
		foreach (rows[i])
		begin
			if (rows[i].w)
				wr_reg(rows[i].a, rows[i].d);
			rd_reg(rows[i].a);
			chk(d, rows[i].e);
		end
		// Interrupt recognition against the mask
		wr_reg(rir_pkg::REG_SR, 32'h0000_0002);
		// Level 4 low for a single cycle only
		@(posedge sys_clk_i);
		raise <= 7'h08;
		@(posedge sys_clk_i);
		raise <= '0;
		drop <= 7'h08;
		req('0, '0, '0);
		repeat (8) @(negedge sys_clk_i);
		chk(32'(int_pend_o), 32'h0000_0000);
		req(7'h02, '0, '0);
		repeat (8) @(negedge sys_clk_i);
		chk(32'(int_pend_o), 32'h0000_0000);
		req(7'h14, '0, '0);
		wait_sig(5, 1'b1);
		repeat (2) @(negedge sys_clk_i);
		chk(32'(int_level_o), 32'h0000_0005);
		serve(1'b0, 3'h5);
		rd_reg(rir_pkg::REG_SR);
		chk(d, 32'h0000_000D);
		repeat (6) @(negedge sys_clk_i);
		chk(32'(int_pend_o), 32'h0000_0000);
		wr_reg(rir_pkg::REG_SR, 32'h0000_0000);
		repeat (2) @(negedge sys_clk_i);
		chk(32'(int_level_o), 32'h0000_0003);
		serve(1'b1, 3'h3);
		// Let the released level-3 line pass the synchroniser
		repeat (4) @(negedge sys_clk_i);
		wr_reg(rir_pkg::REG_SR, 32'h0000_0000);
		wait_sig(5, 1'b1);
		serve(1'b0, 3'h2);
		// Level 7 edge and mask drop
		wr_reg(rir_pkg::REG_SR, 32'h0000_0007);
		req(7'h40, 7'h40, '0);
		wait_sig(5, 1'b1);
		serve(1'b0, 3'h7);
		repeat (8) @(negedge sys_clk_i);
		chk(32'(int_pend_o), 32'h0000_0000);
		wr_reg(rir_pkg::REG_SR, 32'h0000_0000);
		wait_sig(5, 1'b1);
		serve(1'b0, 3'h7);
		req('0, '0, 7'h40);
		// Level 7 must read high before the mask drops again
		repeat (6) @(negedge sys_clk_i);
		// Internal reset waits for a bus cycle end
		wr_reg(rir_pkg::REG_SR, 32'h0000_0030);
		wr_reg(rir_pkg::REG_VTB, 32'h0000_1000);
		@(posedge sys_clk_i);
		int_rst_req_i <= 1'b1;
		repeat (6) @(negedge sys_clk_i);
		chk(32'(master_reset_o), 32'h0000_0000);
		@(posedge sys_clk_i);
		bus_cycle_end_i <= 1'b1;
		@(posedge sys_clk_i);
		bus_cycle_end_i <= 1'b0;
		int_rst_req_i <= 1'b0;
		@(negedge sys_clk_i);
		chk(32'({master_reset_o, abort_o}), 32'h0000_0003);
		t0 = $time;
		wait_sig(2, 1'b1);
		chk(gap(), 32'h0000_0004);
		rd_reg(rir_pkg::REG_CAUSE);
		chk(d, 32'h0000_0001);
		rd_reg(rir_pkg::REG_SR);
		chk(d, 32'h0000_000F);
		rd_reg(rir_pkg::REG_VTB);
		chk(d, 32'h0000_0000);
		@(posedge sys_clk_i);
		{boot_ram_i, slow, breakpoint_input_n_i} <= 3'h7;
		wait_sig(1, 1'b0);
		chk(gap(), 32'h0000_0200);
		wait_sig(3, 1'b1);
		chk(32'(boot_cs_n_o), 32'h0000_0001);
		wait_sig(4, 1'b1);
		rd_reg(rir_pkg::REG_CAUSE);
		chk(d, 32'h0000_0008);
		rd_reg(rir_pkg::REG_CTRL);
		chk(d, 32'h0000_0041);
		// Software and pin reset together; pin held through a test
		@(posedge sys_clk_i);
		ext_low <= 1'b1;
		wr_reg(rir_pkg::REG_CTRL, 32'h0000_0001);
		repeat (6) @(negedge sys_clk_i);
		@(posedge sys_clk_i);
		bus_cycle_end_i <= 1'b1;
		wait_sig(0, 1'b1);
		wait_sig(1, 1'b0);
		repeat (14) @(negedge sys_clk_i);
		chk(32'(ext_reset_oe_o), 32'h0000_0001);
		@(posedge sys_clk_i);
		ext_low <= 1'b0;
		wait_sig(4, 1'b1);
		rd_reg(rir_pkg::REG_CAUSE);
		chk(d, 32'h0000_0006);
		summarize();
	end
endmodule : testbench
